// *** design/hwm_pkg.sv ***
// Constants, types and register map of the hardware-monitor config bank.
// Assumes a 10 MHz clock and word-aligned AHB-Lite register access.
// What this block does
// - Two-bit source code picks system, processor or auxiliary fan temperature.
// - Converter clock code gives 22.5 kHz divided by 1, 4, 16 or 64.
// - Control bit 6 picks comparator or two-times irq for cpu/aux temps.
// - Control bit 5 picks one-time or two-times irq for system temp.
// - Bits 4 and 3 stop aux and processor sensors driving over-temp pin.
// - Polarity bit makes the over-temperature pin active high or low.
// - Each tach pin direction bit: 1 input, 0 fan control output.
// - An output tach pin drives the level held in its value bit.
// - High-byte select picks which identity byte a read returns.
// - Bank field maps indices 50h-5Fh onto bank 0, 1 or 2.
// - Bank select bits 5 and 4 enable alarm for the two b-tachs.
// - Sixteen-bit vendor identity is read-only, one byte per read.
// - First alarm-enable register holds eight per-source enables, reset zero.
// - Second alarm-enable register holds six more per-source enables.
// - Global alarm bit, reset one, gates every alarm source.
// - Eight-bit chip identity register reads a fixed code while bank 0 is selected.
// - Diode mode bits act only for inputs whose sensor type is diode.
// - Sensor type bits choose diode (1) or thermistor (0) per input.
// - After battery enable rises, reading updates after one full cycle.
// - Three-bit divisor code selects fan divisor 1 through 128.
// - Divisor-one register holds low code bits of two tachometers.
// - Fan reading counts clocks per revolution scaled by the divisor.
package hwm_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam real ADC_BASE_KHZ = 22.5;
  localparam int ADC_BASE_CYCLES =
    int'($floor(CLK_HZ / 1000.0 / ADC_BASE_KHZ));
  localparam int ADC_DIV_STEP = 2; // Each code step divides by four
  localparam int AHB_AW = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] IDX_VENDOR = 8'h4f;
  localparam logic [7:0] IDX_CHIP = 8'h58;
  localparam logic [7:0] IDX_BANKED_LO = 8'h50;
  localparam logic [7:0] IDX_BANKED_HI = 8'h5f;
  localparam int NREG = 10;
  localparam int R_FD1 = 0, R_TSRC = 1, R_FD2 = 2, R_IRQC = 3, R_PINC = 4;
  localparam int R_BS = 5, R_AL1 = 6, R_AL2 = 7, R_DS = 8, R_VB = 9;
  localparam logic [7:0] REG_IDX [NREG] = '{8'h47, 8'h4a, 8'h4b, 8'h4c,
    8'h4d, 8'h4e, 8'h56, 8'h57, 8'h59, 8'h5d};
  localparam logic [7:0] REG_RST [NREG] = '{8'h55, 8'h64, 8'h44, 8'h10,
    8'h15, 8'h80, 8'h00, 8'h80, 8'h70, 8'h00};
  localparam int FD1_CPUA_LO = 6, FD1_SYS_LO = 4, FD1_CPUB_VAL = 3;
  localparam int FD1_CPUB_DIR = 2, FD1_AUXB_VAL = 1, FD1_AUXB_DIR = 0;
  localparam int FD2_AUXA_LO = 6, FD2_ADC_LO = 4;
  localparam int IC_CPUB_DIV2 = 7, IC_CMP = 6, IC_ONCE = 5;
  localparam int IC_AUX_OVT_DIS = 4, IC_CPU_OVT_DIS = 3, IC_OVT_POL = 2;
  localparam int PC_AUXA_VAL = 5, PC_AUXA_DIR = 4, PC_CPUA_VAL = 3;
  localparam int PC_CPUA_DIR = 2, PC_SYS_VAL = 1, PC_SYS_DIR = 0;
  localparam int BS_HIGH_BYTE = 7, BS_ALARM_AUXB = 5, BS_ALARM_CPUB = 4;
  localparam int BS_BANK_LO = 0, BANK_W = 3;
  localparam int AL2_GLOBAL = 7, AL2_SRC_W = 6;
  localparam int DS_AUXB_DIV2 = 7, DS_MODE_LO = 4, DS_AUXB_LO = 2;
  localparam int DS_CPUB_LO = 0;
  localparam int VB_AUXA_DIV2 = 7, VB_CPUA_DIV2 = 6, VB_SYS_DIV2 = 5;
  localparam int VB_TYPE_LO = 1, VB_EN = 0;
  localparam int EV_SYS = 0, EV_CPU = 1, EV_AUX = 2;
  localparam int NTACH = 5; // sys, cpu_a, aux_a, cpu_b, aux_b
  localparam logic [1:0] TSRC_SYS = 2'h0, TSRC_CPU = 2'h1, TSRC_AUX = 2'h2;
  typedef enum logic [1:0] {
    BAT_IDLE = 2'b00, BAT_ARMED = 2'b01, BAT_WAIT = 2'b11
  } hwm_bat_t;
  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] cpu;
    logic [7:0] sys;
  } hwm_temps_t;
  // Packed so that it lines up with {bank[5:4], enable two, enable one}
  typedef struct packed {
    logic aux_fan_b, cpu_fan_b;
    logic aux_temp, chassis, aux_fan_a, voltage_input_3, voltage_input_2, voltage_input_1;
    logic cpu_fan_a, sys_fan, cpu_temp, sys_temp, v3v3, analog_supply_monitor, voltage_input_0, vcore;
  } hwm_alarm_src_t;
endpackage

// *** design/hwm_config_bank.sv ***
// Register bank of the hardware monitor: fan temperature source, converter
// clock, irq and over-temperature pin control, tach pins, alarm enables,
// identity, sensor type and battery monitor control.
// Assumes an AHB-Lite master, synchronous inputs, and monitor logic outside.
`timescale 1ns/100ps
module hwm_config_bank import hwm_pkg::*; #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [7:0] CHIP_IDENTITY = 8'h3c, // Arbitrary value
  parameter int ADC_CYCLES = ADC_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire hwm_temps_t temps,
  input wire logic [2:0] temp_event,
  input wire logic cpu_overtemp,
  input wire logic aux_overtemp,
  input wire hwm_alarm_src_t alarm_viol,
  input wire logic monitor_cycle_done,
  input wire logic [NTACH-1:0] tach_in,
  output logic [NTACH-1:0] tach_out,
  output logic [NTACH-1:0] tach_oe,
  output logic [NTACH-1:0] tach_level,
  output logic [NTACH-1:0][7:0] fan_divisor,
  output logic [7:0] fan_drive_temp,
  output logic adc_sample_strobe,
  output logic system_mgmt_irq,
  output logic overtemp_alarm_pin,
  output logic alarm_tone,
  output logic [2:0] sensor_is_diode,
  output logic [2:0] diode_cpu_char,
  output logic battery_enable,
  output logic battery_update
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Banked window only reaches this bank when bank zero is selected
  function automatic logic idx_live(input logic [7:0] idx,
                                    input logic [BANK_W-1:0] bank);
    idx_live = (idx < IDX_BANKED_LO) || (idx > IDX_BANKED_HI) ||
               (bank == '0);
  endfunction

  logic [7:0] rf_q [NREG];
  logic [7:0] rf_d [NREG];
  logic [7:0] rd_or [NREG+1];
  logic wr_q;
  logic [7:0] wr_idx_q;
  logic hreadyout_q, hresp_q;
  logic [31:0] hrdata_q;
  wire logic addr_go = hsel && hready && htrans[1];
  wire logic [7:0] acc_idx = haddr[IDX_LSB +: IDX_W];
  wire logic addr_ok = (haddr[AHB_AW-1:IDX_LSB+IDX_W] == '0);
  wire logic [7:0] wdata = hwdata[7:0];
  // Reads decode against next values so a read right behind a write sees it
  wire logic [BANK_W-1:0] bank_d = rf_d[R_BS][BS_BANK_LO +: BANK_W];
  wire logic acc_live = addr_ok && idx_live(acc_idx, bank_d);
  wire logic hb_sel = rf_d[R_BS][BS_HIGH_BYTE];
  wire logic [7:0] vendor_byte = hb_sel ? VENDOR_ID[15:8] :
                                          VENDOR_ID[7:0];
  wire logic [7:0] ro_byte = (acc_idx == IDX_VENDOR) ? vendor_byte :
                             (acc_idx == IDX_CHIP) ? CHIP_IDENTITY : 8'h00;
  wire logic [7:0] rd_byte = acc_live ? (rd_or[NREG] | ro_byte) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register file: one byte per index, written in the data phase

  assign rd_or[0] = 8'h00;
  for (genvar i = 0; i < NREG; i++) begin : g_rf
    // All bits are stored as written, reserved ones included
    assign rf_d[i] = (wr_q && wr_idx_q == REG_IDX[i]) ? wdata : rf_q[i];
    assign rd_or[i+1] = rd_or[i] | ((acc_idx == REG_IDX[i]) ? rf_d[i] :
                                                              8'h00);
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rf_q[i] <= REG_RST[i];
      end else begin
        rf_q[i] <= rf_d[i];
      end
    end
  end

  // Zero-wait slave; writes to read-only or absent indices are dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      wr_q <= addr_go && hwrite && acc_live;
      wr_idx_q <= acc_idx;
      hrdata_q <= (addr_go && !hwrite) ? {24'h0, rd_byte} : 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  wire logic [7:0] fd1 = rf_q[R_FD1];
  wire logic [7:0] fd2 = rf_q[R_FD2];
  wire logic [7:0] irqc = rf_q[R_IRQC];
  wire logic [7:0] pinc = rf_q[R_PINC];
  wire logic [7:0] bsel = rf_q[R_BS];
  wire logic [7:0] ds = rf_q[R_DS];
  wire logic [7:0] vb = rf_q[R_VB];
  wire logic [NTACH-1:0] tach_dir = {fd1[FD1_AUXB_DIR], fd1[FD1_CPUB_DIR],
    pinc[PC_AUXA_DIR], pinc[PC_CPUA_DIR], pinc[PC_SYS_DIR]};
  wire logic [NTACH-1:0] tach_val = {fd1[FD1_AUXB_VAL], fd1[FD1_CPUB_VAL],
    pinc[PC_AUXA_VAL], pinc[PC_CPUA_VAL], pinc[PC_SYS_VAL]};
  // Low code bits live apart from bit two for four of the tachs
  wire logic [NTACH-1:0][2:0] div_code = {
    {ds[DS_AUXB_DIV2], ds[DS_AUXB_LO +: 2]},
    {irqc[IC_CPUB_DIV2], ds[DS_CPUB_LO +: 2]},
    {vb[VB_AUXA_DIV2], fd2[FD2_AUXA_LO +: 2]},
    {vb[VB_CPUA_DIV2], fd1[FD1_CPUA_LO +: 2]},
    {vb[VB_SYS_DIV2], fd1[FD1_SYS_LO +: 2]}};
  wire logic [1:0] tsrc = rf_q[R_TSRC][1:0];
  wire logic [7:0] temp_pick = (tsrc == TSRC_SYS) ? temps.sys :
                               (tsrc == TSRC_CPU) ? temps.cpu :
                               (tsrc == TSRC_AUX) ? temps.aux :
                                                    8'h00;
  wire logic [2:0] s_type = vb[VB_TYPE_LO +: 3];
  wire logic [2:0] d_mode = ds[DS_MODE_LO +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Fan pins, divisors and temperature source

  logic [NTACH-1:0] tach_out_q, tach_oe_q, tach_level_q;
  logic [NTACH-1:0][7:0] fan_div_q;
  logic [7:0] fan_temp_q;
  logic [2:0] s_diode_q, d_char_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tach_out_q <= '0;
      tach_oe_q <= '0;
      tach_level_q <= '0;
      fan_temp_q <= 8'h00;
      s_diode_q <= 3'h0;
      d_char_q <= 3'h0;
    end else begin
      tach_oe_q <= ~tach_dir;
      tach_out_q <= tach_val;
      tach_level_q <= tach_in & tach_dir; // Counter sees inputs only
      fan_temp_q <= temp_pick;
      s_diode_q <= s_type;
      d_char_q <= s_type & d_mode;
    end
  end
  // Divisor as a count scale for the per-revolution readings
  for (genvar t = 0; t < NTACH; t++) begin : g_div
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        fan_div_q[t] <= 8'h01;
      end else begin
        fan_div_q[t] <= 8'h01 << div_code[t];
      end
    end
  end
  assign tach_out = tach_out_q;
  assign tach_oe = tach_oe_q;
  assign tach_level = tach_level_q;
  assign fan_divisor = fan_div_q;
  assign fan_drive_temp = fan_temp_q;
  assign sensor_is_diode = s_diode_q;
  assign diode_cpu_char = d_char_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock: base tick, then a post-divider of 1, 4, 16 or 64

  localparam int ACW = $clog2(ADC_CYCLES);
  logic [ACW-1:0] acnt_q;
  logic [5:0] pdiv_q;
  logic adc_q;
  wire logic [1:0] adc_code = fd2[FD2_ADC_LO +: 2];
  wire logic [5:0] pdiv_last = 6'((7'h01 << (ADC_DIV_STEP * adc_code)) - 1);
  wire logic atick = (acnt_q == ACW'(ADC_CYCLES - 1));
  // Compare with >= so a smaller code written mid-count cannot wrap long
  wire logic pwrap = atick && (pdiv_q >= pdiv_last);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acnt_q <= '0;
      pdiv_q <= 6'h00;
      adc_q <= 1'b0;
    end else begin
      acnt_q <= atick ? '0 : acnt_q + 1'b1;
      pdiv_q <= pwrap ? 6'h00 : (atick ? pdiv_q + 1'b1 : pdiv_q);
      adc_q <= pwrap;
    end
  end
  assign adc_sample_strobe = adc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and over-temperature pin

  logic [2:0] ev_prev_q;
  logic irq_q, ovt_q;
  wire logic [2:0] ev_edge = temp_event ^ ev_prev_q;
  wire logic [2:0] ev_rise = temp_event & ~ev_prev_q;
  wire logic sys_irq = irqc[IC_ONCE] ? ev_rise[EV_SYS] :
                                       ev_edge[EV_SYS];
  wire logic cpu_irq = irqc[IC_CMP] ? temp_event[EV_CPU] :
                                      ev_edge[EV_CPU];
  wire logic aux_irq = irqc[IC_CMP] ? temp_event[EV_AUX] :
                                      ev_edge[EV_AUX];
  wire logic ovt_act = (aux_overtemp && !irqc[IC_AUX_OVT_DIS]) ||
                       (cpu_overtemp && !irqc[IC_CPU_OVT_DIS]);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_prev_q <= 3'h0;
      irq_q <= 1'b0;
      ovt_q <= 1'b1; // Idle level for the active-low reset polarity
    end else begin
      ev_prev_q <= temp_event;
      irq_q <= sys_irq || cpu_irq || aux_irq;
      ovt_q <= irqc[IC_OVT_POL] ? ovt_act : !ovt_act;
    end
  end
  assign system_mgmt_irq = irq_q;
  assign overtemp_alarm_pin = ovt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm tone

  logic alarm_q;
  wire hwm_alarm_src_t alarm_en = {bsel[BS_ALARM_AUXB], bsel[BS_ALARM_CPUB],
    rf_q[R_AL2][AL2_SRC_W-1:0], rf_q[R_AL1]};
  wire logic al_global = rf_q[R_AL2][AL2_GLOBAL];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= al_global && |(alarm_viol & alarm_en);
    end
  end
  assign alarm_tone = alarm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Battery monitor: first done marks a cycle start, the second its end

  hwm_bat_t bat_q, bat_d;
  logic bat_en_prev_q, bat_upd_q;
  wire logic bat_en = vb[VB_EN];
  assign bat_d = !bat_en ? BAT_IDLE :
                 (bat_q == BAT_IDLE && !bat_en_prev_q) ? BAT_ARMED :
                 (bat_q == BAT_ARMED && monitor_cycle_done) ? BAT_WAIT :
                 (bat_q == BAT_WAIT && monitor_cycle_done) ? BAT_IDLE :
                 bat_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bat_q <= BAT_IDLE;
      bat_en_prev_q <= 1'b0;
      bat_upd_q <= 1'b0;
    end else begin
      bat_q <= bat_d;
      bat_en_prev_q <= bat_en;
      bat_upd_q <= bat_en && bat_q == BAT_WAIT &&
                   monitor_cycle_done;
    end
  end
  assign battery_enable = bat_en_prev_q;
  assign battery_update = bat_upd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire logic rd_go = addr_go && !hwrite;
  sequence s_pinc_write;
    addr_go && hwrite && acc_idx == REG_IDX[R_PINC] && addr_ok;
  endsequence
  // Second monitor-cycle end seen while still enabled
  sequence s_bat_full;
    bat_en && bat_q == BAT_WAIT && monitor_cycle_done;
  endsequence

  a_tach_pin_drive: assert property (s_pinc_write
    |=> ##2 tach_oe_q[2:0] == ~{$past(wdata[PC_AUXA_DIR], 2),
    $past(wdata[PC_CPUA_DIR], 2), $past(wdata[PC_SYS_DIR], 2)})
    else $error("tach pin enable does not follow written direction");
  a_tach_pin_value: assert property (s_pinc_write |=> ##2
    tach_out_q[0] == $past(wdata[PC_SYS_VAL], 2))
    else $error("tach pin level does not follow written value");
  a_ovt_idle_level: assert property (!cpu_overtemp && !aux_overtemp
    |=> ovt_q == !$past(irqc[IC_OVT_POL]))
    else $error("over-temp pin not at idle level");
  a_ovt_cpu_drive: assert property (cpu_overtemp && !irqc[IC_CPU_OVT_DIS]
    |=> ovt_q == $past(irqc[IC_OVT_POL]))
    else $error("enabled cpu over-temp did not assert pin");
  a_alarm_global_off: assert property (!al_global |=> !alarm_q)
    else $error("alarm sounded with global alarm off");
  a_alarm_any_src: assert property (al_global && |(alarm_viol & alarm_en)
    |=> alarm_q)
    else $error("enabled violation did not sound alarm");
  a_irq_comparator: assert property ((irqc[IC_CMP] &&
    temp_event[EV_CPU]) [*2] |-> irq_q)
    else $error("comparator mode irq not held");
  a_irq_one_time: assert property ($fell(temp_event[EV_SYS]) &&
    irqc[IC_ONCE] && temp_event[2:1] == 2'h0 &&
    $past(temp_event[2:1]) == 2'h0 |=> !irq_q)
    else $error("one-time mode fired on exit");
  a_irq_two_times: assert property ($fell(temp_event[EV_SYS]) &&
    !irqc[IC_ONCE] |=> irq_q)
    else $error("two-times mode missed exit event");
  a_vendor_byte: assert property (rd_go && acc_idx == IDX_VENDOR &&
    addr_ok && !wr_q |=> hrdata_q[7:0] == ($past(bsel[BS_HIGH_BYTE]) ?
    VENDOR_ID[15:8] : VENDOR_ID[7:0]))
    else $error("vendor identity byte select wrong");
  a_bank_hidden: assert property (rd_go && !wr_q && bsel[2:0] != 3'h0 &&
    acc_idx == IDX_CHIP |=> hrdata_q == 32'h0)
    else $error("bank zero register visible in other bank");
  a_diode_gate: assert property ((d_char_q & ~s_diode_q) == 3'h0)
    else $error("diode mode active on thermistor input");
  a_battery_update: assert property (s_bat_full
    |=> bat_upd_q)
    else $error("battery reading not updated after full cycle");
  a_battery_early: assert property ($rose(bat_en)
    |-> !bat_upd_q [*3])
    else $error("battery reading updated too early");
  a_adc_spacing: assert property (adc_q
    |=> !adc_q [*3])
    else $error("converter strobes too close together");

endmodule

// *** dv/hwm_far_side.sv ***
// Far-side model of the config bank: sensors, fans and alarm sources.
// Assumes the bench commands event, over-temperature and violation levels.
`timescale 1ns/100ps
module hwm_far_side import hwm_pkg::*; #(
  parameter int CYC = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] ev_cmd,
  input wire logic [1:0] ovt_cmd,
  input wire hwm_alarm_src_t viol_cmd,
  input wire logic [NTACH-1:0] tach_out,
  input wire logic [NTACH-1:0] tach_oe,
  output hwm_temps_t temps,
  output logic [2:0] temp_event,
  output logic cpu_overtemp,
  output logic aux_overtemp,
  output hwm_alarm_src_t alarm_viol,
  output logic monitor_cycle_done,
  output logic [NTACH-1:0] tach_in
);
  int cnt_q;
  logic fan_q;
  // Distinct readings, so a wrong source pick shows at once
  assign temps = '{aux: 8'h43, cpu: 8'h32, sys: 8'h21};
  assign temp_event = ev_cmd;
  assign cpu_overtemp = ovt_cmd[0];
  assign aux_overtemp = ovt_cmd[1];
  assign alarm_viol = viol_cmd;
  assign monitor_cycle_done = (cnt_q == CYC - 1);
  // The bank's drive wins the pin, else the fan's tach wave shows
  assign tach_in = (tach_oe & tach_out) |
                   (~tach_oe & {NTACH{fan_q}});
  ////////////////////////////////////////////////////////////////////////////
  // Monitor cycle counter; the tach wave toggles once per cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      fan_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == CYC - 1) ? 0 : cnt_q + 1;
      fan_q <= (cnt_q == CYC - 1) ? ~fan_q : fan_q;
    end
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench of the config bank, driven over AHB-Lite.
// Assumes the far-side model stands in for sensors, fans and alarms.
`timescale 1ns/100ps
module tb import hwm_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, ovt_cmd = 2'h0;
  logic [2:0] ev_cmd = 3'h0, diode, dchar;
  logic hresp, irq, ovt, tone, bat_en, bat_upd, strobe;
  logic [NTACH-1:0] t_in, t_out, t_oe, t_lvl;
  logic [NTACH-1:0][7:0] fdiv;
  logic [7:0] ftemp, rd;
  hwm_alarm_src_t viol = '0, viol_w;
  hwm_temps_t temps;
  logic [2:0] tev;
  logic cpu_ot, aux_ot, mdone;
  int mismatches = 0, num_checks = 0, n;
  always #50 clk = ~clk;
  logic hready_o;
  assign hready = hready_o;
  hwm_config_bank #(.ADC_CYCLES(4)) DUT (.clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready_o),
    .hresp(hresp), .hrdata(hrdata), .temps(temps), .temp_event(tev),
    .cpu_overtemp(cpu_ot), .aux_overtemp(aux_ot), .alarm_viol(viol_w),
    .monitor_cycle_done(mdone), .tach_in(t_in), .tach_out(t_out),
    .tach_oe(t_oe), .tach_level(t_lvl), .fan_divisor(fdiv),
    .fan_drive_temp(ftemp), .adc_sample_strobe(strobe),
    .system_mgmt_irq(irq), .overtemp_alarm_pin(ovt), .alarm_tone(tone),
    .sensor_is_diode(diode), .diode_cpu_char(dchar),
    .battery_enable(bat_en), .battery_update(bat_upd));
  hwm_far_side #(.CYC(16)) far (.clk(clk), .rstn(rstn), .ev_cmd(ev_cmd),
    .ovt_cmd(ovt_cmd), .viol_cmd(viol), .tach_out(t_out), .tach_oe(t_oe),
    .temps(temps), .temp_event(tev), .cpu_overtemp(cpu_ot),
    .aux_overtemp(aux_ot), .alarm_viol(viol_w), .monitor_cycle_done(mdone),
    .tach_in(t_in));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict in one place; a hang is cut short here too
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      mismatches++;
    end
  endtask
  // One single transfer; called right after a rising edge
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [7:0] r);
    int k;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    k = 0;
    do begin @(posedge clk); k++; end while (hready_o !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    k = 0;
    do begin @(posedge clk); k++; end while (hready_o !== 1'b1 && k < 50);
    r = hrdata[7:0];
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(idx, 1'b1, wd, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00, rd);
    chk({24'h0, rd}, {24'h0, exp}, "read data");
  endtask
  // Irq pulses seen over a fixed span
  task automatic irq_count(output int c);
    c = 0;
    repeat (8) begin @(posedge clk); c += (irq === 1'b1); end
  endtask
  initial begin
    #(100 * 20000);
    mismatches++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NREG; i++) rdchk(REG_IDX[i], REG_RST[i]);
    for (int i = 0; i < NREG; i++) begin
      if (i != R_BS) begin
        wr(REG_IDX[i], (i == R_FD2) ? 8'hb4 : ~REG_RST[i]);
        rdchk(REG_IDX[i], (i == R_FD2) ? 8'hb4 : ~REG_RST[i]);
        wr(REG_IDX[i], REG_RST[i]);
      end
    end
    rdchk(IDX_VENDOR, 8'h12);
    rdchk(IDX_CHIP, 8'h3c);
    wr(IDX_CHIP, 8'h55);
    wr(IDX_VENDOR, 8'h55);
    wr(8'h49, 8'h77);
    rdchk(8'h49, 8'h00);
    rdchk(IDX_CHIP, 8'h3c);
    wr(8'h4e, 8'h00);
    rdchk(IDX_VENDOR, 8'h34);
    wr(8'h4e, 8'h01);
    wr(8'h56, 8'hff);
    rdchk(8'h56, 8'h00);
    wr(8'h4e, 8'h80);
    rdchk(8'h56, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h4a, 8'h64 | c[7:0]);
      chk(ftemp, (c == 0) ? 8'h21 : (c == 1) ? 8'h32 :
          (c == 2) ? 8'h43 : 8'h00, "fan temp source");
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h47, {2'b01, c[1:0], 4'h5});
      wr(8'h5d, {2'b00, c[2], 5'h00});
      chk(fdiv[0], 8'h01 << c, "fan divisor");
    end
    wr(8'h4d, 8'h22);
    chk(t_oe[2:0], 3'b111, "tach drive enable");
    chk({t_out[2:0], t_lvl[2:0]}, 6'b101000, "tach drive level");
    wr(8'h4d, 8'h15);
    chk(t_oe, 5'h00, "tach back to input");
    // Over-temp pin: sources, disables and polarity
    ovt_cmd <= 2'b01;
    wr(8'h4c, 8'h10);
    chk(ovt, 1'b0, "ovt active low");
    wr(8'h4c, 8'h14);
    chk(ovt, 1'b1, "ovt active high");
    wr(8'h4c, 8'h1c);
    chk(ovt, 1'b0, "cpu ovt disabled");
    ovt_cmd <= 2'b10;
    wr(8'h4c, 8'h04);
    chk(ovt, 1'b1, "aux ovt enabled");
    // Irq modes: comparator level, then two-times and one-time pulses
    wr(8'h4c, 8'h50);
    ev_cmd <= 3'b010;
    repeat (3) @(posedge clk);
    chk(irq, 1'b1, "comparator irq level");
    ev_cmd <= 3'b000;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "comparator irq cleared");
    for (int m = 0; m < 2; m++) begin
      wr(8'h4c, m ? 8'h30 : 8'h10);
      ev_cmd <= 3'b001;
      irq_count(n);
      chk(n, 1, "irq on entry");
      ev_cmd <= 3'b000;
      irq_count(n);
      chk(n, (m == 0) ? 1 : 0, "irq on leave");
    end
    // Alarm tone gating
    viol <= 16'h4001;
    wr(8'h56, 8'h01);
    chk(tone, 1'b1, "tone on source");
    wr(8'h57, 8'h00);
    chk(tone, 1'b0, "global silence");
    wr(8'h57, 8'h80);
    wr(8'h56, 8'h00);
    chk(tone, 1'b0, "tone disabled");
    wr(8'h4e, 8'h90);
    chk(tone, 1'b1, "tone on b tach");
    wr(8'h4e, 8'h80);
    wr(8'h5d, 8'h06);
    chk({diode, dchar}, 6'b011011, "sensor type and diode mode");
    // Battery reading: update after one full monitor cycle
    bus(8'h5d, 1'b1, 8'h01, rd);
    n = 0;
    for (int k = 0; k < 60 && bat_upd !== 1'b1; k++) begin
      @(posedge clk);
      n += (mdone === 1'b1);
    end
    chk(bat_en, 1'b1, "battery enable");
    chk(bat_upd, 1'b1, "battery update seen");
    chk(n >= 2 && n <= 3, 1'b1, "battery update timing");
    // Converter strobe period: base 4 times 1, 4, 16, 64
    for (int c = 0; c < 4; c++) begin
      wr(8'h4b, {2'b01, c[1:0], 4'h4});
      for (int s = 0; s < 2; s++) begin
        n = 0;
        do begin @(posedge clk); n++; end while (strobe !== 1'b1 && n < 400);
      end
      chk(n, 4 << (2 * c), "converter strobe period");
    end
    finish_test();
  end
endmodule
